// >>> host_port_pkg.sv
package host_port_pkg;

   // Address map of the 64K window
   localparam logic [15:0] BUFFER_BASE = 16'h0000;
   localparam logic [15:0] BUFFER_LAST = 16'h9fff;
   localparam logic [15:0] REG_BASE = 16'hffe0;
   localparam int REG_WORDS = 16;

   // Register indices and fields
   localparam logic [3:0] PANEL_CTRL_REG = 4'h0;
   localparam int PANEL_ON_BIT = 0;
   localparam logic [3:0] STRAP_STATUS_REG = 4'h1;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Cycles from reset release until the strap synchronisers have settled
   localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

   // Pins idle high
   localparam logic [35:0] HOST_PINS_IDLE = 36'hfffffffff;
   localparam logic [5:0] STRAP_PINS_IDLE = 6'h3f;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic lower_write_enable_n;
      logic upper_lane_enable_n;
      logic [15:0] addr;
      logic [15:0] data;
   } host_pins_t;

   typedef struct packed {
      logic panel_power_polarity_strap;
      logic byte_order_strap;
      logic strap_two;
      logic strap_one;
      logic strap_zero;
      logic bus_status_strap_n;
   } strap_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARB = 2'b01,
      ST_XFER = 2'b10,
      ST_DONE = 2'b11
   } port_state_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Pins and settled value
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] value_o
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, val_q, val_d;

   // A bit changes once the second and third stages agree
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_comb begin
            val_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : val_q[b];
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         val_q <= RESET_VAL;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         val_q <= val_d;
      end
   end

   assign value_o = val_q;
endmodule
`default_nettype wire

// >>> host_port.sv
// Function
// - Wait line low until data ready/taken
// - Stall host while refresh owns resource
// - Straps latched once settled, five cycles after reset release
// - Strap three selects byte order
// - Strap four sets panel power polarity
// - Straps zero to two and bus status strap all high select generic 16-bit mode
// - Display buffer at window offset zero
// - Registers decode from offset FFE0h upward
`timescale 1ns/10ps
`default_nettype none
module host_port
   import host_port_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host pins
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic lower_write_enable_n_i,
   input wire logic upper_lane_enable_n_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   output logic data_oe_o,
   output logic wait_n_o,
   // Straps
   input wire logic [5:0] straps_i,
   // Display buffer port and refresh contention
   input wire logic refresh_busy_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [14:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   output logic [1:0] mem_be_o,
   input wire logic [15:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // Configuration and panel
   output logic byte_order_o,
   output logic generic_mode_o,
   output logic panel_power_control_o
);
   host_pins_t pins;
   strap_pins_t strap_pins;
   pin_sync #(.WIDTH(36), .RESET_VAL(HOST_PINS_IDLE)) u_host_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i({cs_n_i, rd_n_i, lower_write_enable_n_i, upper_lane_enable_n_i, addr_i, data_i}),
      .value_o(pins)
   );
   pin_sync #(.WIDTH(6), .RESET_VAL(STRAP_PINS_IDLE)) u_strap_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i(straps_i),
      .value_o(strap_pins)
   );
   // Strap capture, once the synchroniser holds the strap levels
   logic [2:0] settle_q, settle_d;
   logic latched_q, latched_d;
   strap_pins_t straps_q, straps_d;
   logic mode_ok;
   always_comb begin
      settle_d = settle_q;
      latched_d = latched_q;
      straps_d = straps_q;
      if (!latched_q) begin
         if (settle_q == STRAP_SETTLE_CYCLES) begin
            latched_d = 1'b1;
            straps_d = strap_pins;
         end else begin
            settle_d = settle_q + 3'h1;
         end
      end
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         settle_q <= 3'h0;
         latched_q <= 1'b0;
         straps_q <= STRAP_PINS_IDLE;
      end else begin
         settle_q <= settle_d;
         latched_q <= latched_d;
         straps_q <= straps_d;
      end
   end
   assign mode_ok = latched_q & straps_q.strap_two & straps_q.strap_one &
                    straps_q.strap_zero & straps_q.bus_status_strap_n;
   // Access sequencer
   port_state_t state_q, state_d;
   logic wait_n_q, wait_n_d, oe_q, oe_d, is_rd_q, is_rd_d;
   logic [15:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic [1:0] be_q, be_d;
   logic mem_req_q, mem_req_d, mem_we_q, mem_we_d, mode_q;
   logic start, swap, in_buf, in_reg, reg_wr;
   logic [15:0] host_wdata, reg_rdata;
   logic [1:0] host_be;
   logic [15:0] regs_q [REG_WORDS];
   logic [15:0] regs_d [REG_WORDS];
   assign swap = straps_q.byte_order_strap;
   assign start = !pins.cs_n && (!pins.rd_n || !pins.lower_write_enable_n);
   // lane enables from address bit zero and upper enable
   assign host_be = {~pins.upper_lane_enable_n, ~pins.addr[0]};
   assign host_wdata = swap ? {pins.data[7:0], pins.data[15:8]} : pins.data;
   assign in_buf = (addr_q >= BUFFER_BASE) && (addr_q <= BUFFER_LAST);
   assign in_reg = addr_q >= REG_BASE;
   assign reg_wr = (state_q == ST_ARB) && !refresh_busy_i && in_reg && !is_rd_q;
   assign reg_rdata = (addr_q[4:1] == STRAP_STATUS_REG) ? {10'h000, straps_q} :
                      regs_q[addr_q[4:1]];
   always_comb begin
      state_d = state_q;
      wait_n_d = wait_n_q;
      oe_d = oe_q;
      is_rd_d = is_rd_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      be_d = be_q;
      mem_req_d = mem_req_q;
      unique case (state_q)
         ST_IDLE: begin
            if (mode_ok && start) begin
               wait_n_d = 1'b0;
               is_rd_d = !pins.rd_n;
               addr_d = pins.addr;
               wdata_d = host_wdata;
               be_d = swap ? {host_be[0], host_be[1]} : host_be;
               state_d = ST_ARB;
            end
         end
         ST_ARB: begin
            if (!refresh_busy_i) begin
               if (in_buf) begin
                  mem_req_d = 1'b1;
                  state_d = ST_XFER;
               end else begin
                  rdata_d = in_reg ? reg_rdata : 16'h0000;
                  state_d = ST_DONE;
               end
            end
         end
         ST_XFER: begin
            if (mem_ack_i) begin
               mem_req_d = 1'b0;
               rdata_d = mem_rdata_i;
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            wait_n_d = 1'b1;
            oe_d = is_rd_q && !pins.cs_n && !pins.rd_n;
            if (pins.cs_n || (pins.rd_n && pins.lower_write_enable_n)) begin
               oe_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
      endcase
      mem_we_d = !is_rd_d;
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         mode_q <= 1'b0;
         mem_we_q <= 1'b1;
         wait_n_q <= 1'b1;
         oe_q <= 1'b0;
         is_rd_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
         be_q <= 2'h0;
         mem_req_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_n_q <= wait_n_d;
         oe_q <= oe_d;
         is_rd_q <= is_rd_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         be_q <= be_d;
         mem_req_q <= mem_req_d;
         mode_q <= mode_ok;
         mem_we_q <= mem_we_d;
      end
   end
   // Register set, strap status word is read only
   genvar r;
   generate
      for (r = 0; r < REG_WORDS; r++) begin : g_reg
         always_comb begin
            regs_d[r] = regs_q[r];
            if (reg_wr && (addr_q[4:1] == 4'(r)) && (4'(r) != STRAP_STATUS_REG)) begin
               if (be_q[1]) regs_d[r][15:8] = wdata_q[15:8];
               if (be_q[0]) regs_d[r][7:0] = wdata_q[7:0];
            end
         end
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               regs_q[r] <= REG_RESET;
            end else begin
               regs_q[r] <= regs_d[r];
            end
         end
      end
   endgenerate
   // Output stage
   logic [15:0] data_out_d, data_out_q;
   logic panel_d, panel_q;
   logic panel_on;
   assign panel_on = regs_q[PANEL_CTRL_REG][PANEL_ON_BIT];
   always_comb begin
      data_out_d = swap ? {rdata_q[7:0], rdata_q[15:8]} : rdata_q;
      panel_d = straps_q.panel_power_polarity_strap ? panel_on : ~panel_on;
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_out_q <= 16'h0000;
         panel_q <= 1'b0;
      end else begin
         data_out_q <= data_out_d;
         panel_q <= panel_d;
      end
   end
   assign data_o = data_out_q;
   assign data_oe_o = oe_q;
   assign wait_n_o = wait_n_q;
   assign mem_req_o = mem_req_q;
   assign mem_we_o = mem_we_q;
   assign mem_addr_o = addr_q[15:1];
   assign mem_wdata_o = wdata_q;
   assign mem_be_o = be_q;
   assign byte_order_o = straps_q.byte_order_strap;
   assign generic_mode_o = mode_q;
   assign panel_power_control_o = panel_q;
   // Checks
   sequence seq_grant;
      state_q == ST_ARB && !refresh_busy_i;
   endsequence
   sequence seq_start;
      state_q == ST_IDLE && mode_ok && start;
   endsequence
   AST_WAIT_ON_START: assert property (
      @(posedge clk_i) disable iff (!resetn_i) seq_start |=> !wait_n_o && state_q == ST_ARB)
      else $error("wait not asserted on access");
   AST_WAIT_RELEASE: assert property (
      @(posedge clk_i) disable iff (!resetn_i) $rose(wait_n_o) |-> state_q == ST_DONE)
      else $error("wait released outside done");
   AST_REFRESH_STALL: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_ARB && refresh_busy_i) |=> (state_q == ST_ARB && !wait_n_o && !mem_req_o))
      else $error("access proceeded during refresh");
   AST_STRAP_CAPTURE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (!latched_q && settle_q == STRAP_SETTLE_CYCLES) |=> latched_q && straps_q == $past(strap_pins))
      else $error("straps not captured");
   AST_BYTE_ORDER_HELD: assert property (
      @(posedge clk_i) disable iff (!resetn_i) latched_q |=> $stable(byte_order_o))
      else $error("byte order changed after capture");
   AST_PANEL_POLARITY: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      latched_q |=> panel_power_control_o ==
         ($past(straps_q.panel_power_polarity_strap) ? $past(panel_on) : !$past(panel_on)))
      else $error("panel power polarity wrong");
   AST_MODE_GATES_ACCESS: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_IDLE && !mode_ok) |=> state_q == ST_IDLE && wait_n_o)
      else $error("access taken outside generic mode");
   AST_BUFFER_MAP: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (seq_grant and (addr_q <= BUFFER_LAST)) |=> mem_req_o && mem_addr_o == $past(addr_q[15:1]))
      else $error("buffer access not forwarded");
   AST_REG_WRITE: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (seq_grant and (in_reg && !is_rd_q && addr_q[4:1] == PANEL_CTRL_REG && be_q[0]))
      |=> regs_q[PANEL_CTRL_REG][7:0] == $past(wdata_q[7:0]) ##1 (state_q == ST_DONE && wait_n_o))
      else $error("register write lost");
endmodule
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model #(
   parameter logic [7:0] WINDOW = 8'h3c
) (
   // Clock
   input wire logic clk_i,
   // Controller pins
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic upper_n_o,
   output logic [15:0] addr_o,
   output logic [15:0] data_o,
   input wire logic [15:0] data_i,
   input wire logic data_oe_i,
   input wire logic wait_n_i
);
   logic cpu_wait;
   assign cpu_wait = ~wait_n_i;
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      upper_n_o = 1'b1;
      addr_o = 16'h0000;
      data_o = 16'h0000;
   end
   // Released lines show a changed pattern
   task automatic release_bus();
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      upper_n_o <= 1'b1;
      addr_o <= ~addr_o;
      data_o <= ~data_o;
   endtask
   // res: 0 no answer, 1 done, 2 hung, 3 data drive wrong for direction
   task automatic access(input logic wr, input logic [23:0] ca, input logic [7:0] wd,
                         output logic [7:0] rd, output logic [1:0] res);
      int n;
      res = 2'h0;
      rd = 8'h00;
      @(posedge clk_i);
      cs_n_o <= (ca[23:16] != WINDOW);
      addr_o <= ca[15:0];
      upper_n_o <= ~ca[0];
      data_o <= {wd, wd};
      rd_n_o <= wr;
      wr_n_o <= ~wr;
      #1;
      for (n = 0; n < 16 && !cpu_wait; n++) begin
         @(posedge clk_i);
         #1;
      end
      if (cpu_wait) begin
         for (n = 0; n < 64 && cpu_wait; n++) begin
            @(posedge clk_i);
            #1;
         end
         res = cpu_wait ? 2'h2 : ((data_oe_i == !wr) ? 2'h1 : 2'h3);
         rd = ca[0] ? data_i[15:8] : data_i[7:0];
      end
      @(posedge clk_i);
      release_bus();
      repeat (8) @(posedge clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module testbench
   import host_port_pkg::*;
;
   logic clk_i, resetn_i, cs_n, rd_n, wr_n, up_n, data_oe_o, wait_n_o;
   logic [15:0] addr, hdata, data_o, mem_wdata_o, mem_rdata_i;
   logic [5:0] straps_i;
   logic refresh_busy_i, mem_req_o, mem_we_o, mem_ack_i;
   logic [14:0] mem_addr_o;
   logic [1:0] mem_be_o, res;
   logic byte_order_o, generic_mode_o, panel_power_control_o;
   logic [7:0] rd;
   logic [15:0] mem [0:20479];
   int err_count, checks, stall, wcnt;

   host_port DUT (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .lower_write_enable_n_i(wr_n), .upper_lane_enable_n_i(up_n), .addr_i(addr),
      .data_i(hdata), .data_o(data_o), .data_oe_o(data_oe_o), .wait_n_o(wait_n_o),
      .straps_i(straps_i), .refresh_busy_i(refresh_busy_i), .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .mem_be_o(mem_be_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
      .byte_order_o(byte_order_o), .generic_mode_o(generic_mode_o),
      .panel_power_control_o(panel_power_control_o));
   host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .upper_n_o(up_n), .addr_o(addr), .data_o(hdata), .data_i(data_o),
      .data_oe_i(data_oe_o), .wait_n_i(wait_n_o));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Buffer responder with adjustable stall
   always @(posedge clk_i) begin
      mem_ack_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i;
      if (mem_req_o && !mem_ack_i) begin
         if (wcnt >= stall) begin
            wcnt <= 0;
            mem_ack_i <= 1'b1;
            mem_rdata_i <= mem[mem_addr_o];
            if (mem_we_o && mem_be_o[0]) mem[mem_addr_o][7:0] <= mem_wdata_o[7:0];
            if (mem_we_o && mem_be_o[1]) mem[mem_addr_o][15:8] <= mem_wdata_o[15:8];
         end else begin
            wcnt <= wcnt + 1;
         end
      end
   end
   task automatic stop_test();
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic [5:0] s);
      @(posedge clk_i);
      straps_i <= s;
      resetn_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      `CHK(wait_n_o, 1'b1)
      `CHK(data_oe_o, 1'b0)
      @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1;
      `CHK(generic_mode_o, &s[3:0])
      `CHK(byte_order_o, s[4])
      `CHK(panel_power_control_o, ~s[5])
   endtask
   task automatic wr8(input logic [23:0] a, input logic [7:0] d, input logic [1:0] er);
      host.access(1'b1, a, d, rd, res);
      `CHK(res, er)
   endtask
   task automatic rd8(input logic [23:0] a, input logic [7:0] e, input logic [1:0] er);
      host.access(1'b0, a, 8'h00, rd, res);
      `CHK(res, er)
      if (er == 2'h1) `CHK(rd, e)
   endtask

   initial begin
      resetn_i = 1'b0;
      straps_i = 6'h3f;
      refresh_busy_i = 1'b0;
      mem_ack_i = 1'b0;
      mem_rdata_i = 16'h0000;
      err_count = 0;
      checks = 0;
      stall = 0;
      wcnt = 0;
      for (int i = 0; i < 20480; i++) mem[i] = 16'h0000;
      // Bus status strap held high
      do_reset(6'h2f);
      wr8(24'h3cffe0, 8'h01, 2'h1);
      `CHK(panel_power_control_o, 1'b1)
      rd8(24'h3cffe0, 8'h01, 2'h1);
      rd8(24'h3cffe1, 8'h00, 2'h1);
      wr8(24'h3cffe2, 8'h55, 2'h1);
      rd8(24'h3cffe2, 8'h2f, 2'h1);
      rd8(24'h3cfffe, 8'h00, 2'h1);
      wr8(24'h3c0000, 8'ha5, 2'h1);
      wr8(24'h3c0001, 8'h5a, 2'h1);
      `CHK(mem[0], 16'h5aa5)
      stall = 6;
      rd8(24'h3c0001, 8'h5a, 2'h1);
      wr8(24'h3c9fff, 8'hc3, 2'h1);
      rd8(24'h3c9fff, 8'hc3, 2'h1);
      wr8(24'h3ca001, 8'h77, 2'h1);
      rd8(24'h3ca001, 8'h00, 2'h1);
      wr8(24'h3d0000, 8'hee, 2'h0);
      `CHK(mem[0], 16'h5aa5)
      fork
         rd8(24'h3c0000, 8'ha5, 2'h1);
         begin
            @(posedge clk_i);
            refresh_busy_i <= 1'b1;
            repeat (24) @(posedge clk_i);
            #1;
            `CHK(wait_n_o, 1'b0)
            @(posedge clk_i);
            refresh_busy_i <= 1'b0;
         end
      join
      do_reset(6'h1f);
      stall = 0;
      wr8(24'h3c0010, 8'h11, 2'h1);
      `CHK(mem[8], 16'h1100)
      rd8(24'h3c0010, 8'h11, 2'h1);
      do_reset(6'h2d);
      rd8(24'h3cffe2, 8'h00, 2'h0);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      stop_test();
   end
endmodule
`default_nettype wire
